// file: standby_watchdog_control.sv
// Operation
// R1: Two clocks at crystal rate are produced, one for timers and interrupts, one for the CPU.
// R2: Halt gates only the CPU clock; oscillator, timers and interrupt capture keep running.
// R3: An enabled interrupt ends halt and execution resumes after the halt instruction.
// R4: The stop instruction stops the oscillator and so both internal clocks.
// R5: Only a reset or a high wake pin level releases stop mode.
// R6: After any reset and after leaving stop, fetch starts at address 000CH.
// R7: Software places a no-operation before stop or halt so the pipeline drains.
// R8: The watchdog is always on and resets the device unless refreshed within 12 ms.
// R9: Power-on reset clears the watchdog and every refresh restarts its period.
// R10: The watchdog-in-halt instruction keeps the watchdog counting during halt.
// R11: The watchdog does not count in stop mode.
// R12: The watchdog refresh writes the zero, sign and overflow flags.
// R13: A low supply report drives a global reset.
// R14: Request line one is set on the leading edge of filtered vertical sync.
// R15: Six maskable prioritised requests: software, vsync, event pin, wake pin, timers.
// R16: The wake pin is level sensed to restart the oscillator without edge sampling.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "standby_regs.svh"
module standby_watchdog_control
#(
  parameter int unsigned WDT_CYCLES = `WDT_CYCLES_DFLT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside the clock domain
  input wire logic wake_input_pin,
  input wire logic external_event_pin,
  input wire logic vsync_filtered,
  input wire logic supply_low_reset,
  // Instruction strobes from the CPU decoder
  input wire logic halt_op,
  input wire logic stop_op,
  input wire logic watchdog_refresh_op,
  input wire logic watchdog_in_halt_op,
  input wire logic soft_irq_req,
  // Timer events
  input wire logic timer_zero,
  input wire logic timer_one,
  // Clock gating
  output logic osc_run,
  output logic cpu_clk_en,
  output logic timer_clk_en,
  // Restart control
  output logic dev_reset,
  output logic fetch_start,
  output standby_pkg::fetch_addr_t fetch_addr,
  output logic halt_resume,
  // Flag register update
  output logic flag_we,
  output logic [2:0] flag_zsv,
  // Interrupt to the CPU
  output logic irq,
  output standby_pkg::irq_id_t irq_vector
);
  import standby_pkg::*;

  mode_t mode_q;
  logic [`PIN_N-1:0] pin_meta_q;
  logic [`PIN_N-1:0] pin_sync_q;
  logic [`PIN_N-1:0] pin_prev_q;
  logic [`PIN_N-1:0] pin_rise;
  irq_vec_t flags_q;
  irq_vec_t mask_q;
  irq_vec_t set_vec;
  irq_vec_t clr_vec;
  irq_vec_t pend_vec;
  logic [1:0] cause_q;
  logic wdh_armed_q;
  logic dev_reset_q;
  logic sys_rst;
  logic rst_prev_q;
  logic fetch_start_q;
  fetch_addr_t fetch_addr_q;
  logic halt_resume_q;
  logic osc_run_q;
  logic cpu_clk_en_q;
  logic timer_clk_en_q;
  logic flag_we_q;
  logic [2:0] flag_zsv_q;
  logic irq_q;
  irq_id_t irq_vector_q;
  logic pending;
  logic wake_lvl;
  logic clocks_on;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [9:0] widx;
  logic acc;
  logic wr_acc;

  wdog_if wd();

  // Lowest request number wins
  function automatic irq_id_t first_set(input irq_vec_t v);
    irq_id_t id;
    id = '0;
    for (int i = `IRQ_SRC_N - 1; i >= 0; i--)
    begin
      if (v[i])
        id = irq_id_t'(i);
    end
    return id;
  endfunction : first_set

  // Two flip-flop synchroniser per pin; only the second stage is read
  generate
    for (genvar p = 0; p < `PIN_N; p++)
    begin : g_sync
      logic pin_in;
      assign pin_in = (p == `PIN_WAKE) ? wake_input_pin :
                      (p == `PIN_EXT) ? external_event_pin :
                      (p == `PIN_VSYNC) ? vsync_filtered :
                      supply_low_reset;
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pin_meta_q[p] <= 1'b0;
          pin_sync_q[p] <= 1'b0;
          pin_prev_q[p] <= 1'b0;
        end
        else
        begin
          pin_meta_q[p] <= pin_in;
          pin_sync_q[p] <= pin_meta_q[p];
          pin_prev_q[p] <= pin_sync_q[p];
        end
      end
      assign pin_rise[p] = pin_sync_q[p] & ~pin_prev_q[p];
    end
  endgenerate

  // Reference clock stays alive, so the wake level is sensed as a level
  assign wake_lvl = pin_sync_q[`PIN_WAKE]; // [R16]

  // Global reset from pin, supply monitor or watchdog
  always_ff @(posedge clk)
  begin
    if (rst)
      dev_reset_q <= 1'b1;
    else
      dev_reset_q <= pin_sync_q[`PIN_SUPPLY] | wd.expired; // [R13] [R8]
  end

  assign sys_rst = rst | dev_reset_q;

  // Write-one-to-clear for the cause bits; a new cause still wins
  function automatic logic [1:0] clr_cause();
    if (wr_acc && widx == `IDX_STATUS)
      return pwdata[`STAT_CAUSE_LSB +: 2];
    return 2'b00;
  endfunction : clr_cause

  // Reset cause record survives the watchdog and supply resets
  always_ff @(posedge clk)
  begin
    if (rst)
      cause_q <= `CAUSE_RST;
    else
      cause_q <= (cause_q & ~clr_cause()) |
                 {pin_sync_q[`PIN_SUPPLY], wd.expired};
  end

  // Power mode sequencing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_q <= MODE_RUN; // [R5]
    end
    else
    begin
      unique case (mode_q)
        MODE_RUN:
        begin
          if (stop_op)
            mode_q <= MODE_STOP; // [R4]
          else if (halt_op)
            mode_q <= MODE_HALT;
        end
        MODE_HALT:
        begin
          if (pending)
            mode_q <= MODE_RUN; // [R3]
        end
        MODE_STOP:
        begin
          if (wake_lvl)
            mode_q <= MODE_RUN; // [R5]
        end
        default:
        begin
          mode_q <= MODE_RUN;
        end
      endcase
    end
  end

  assign clocks_on = (mode_q != MODE_STOP);

  // Clock enables; both clocks share the crystal rate
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_run_q <= 1'b1;
      cpu_clk_en_q <= 1'b1;
      timer_clk_en_q <= 1'b1;
    end
    else
    begin
      osc_run_q <= (mode_q != MODE_STOP) || wake_lvl; // [R4] [R16]
      cpu_clk_en_q <= (mode_q == MODE_RUN); // [R1] [R2]
      timer_clk_en_q <= clocks_on; // [R1] [R2] [R4]
    end
  end

  // Resume pulse for the core after halt
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      halt_resume_q <= 1'b0;
    else
      halt_resume_q <= (mode_q == MODE_HALT) && pending; // [R3]
  end

  // Restart fetch after reset release or wake from stop
  always_ff @(posedge clk)
  begin
    rst_prev_q <= sys_rst;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fetch_start_q <= 1'b0;
    else
      fetch_start_q <= rst_prev_q |
                       ((mode_q == MODE_STOP) && wake_lvl); // [R6]
  end

  // Restart address held in a flop so the port comes from a register
  always_ff @(posedge clk)
  begin
    fetch_addr_q <= `RESTART_ADDR; // [R6]
  end

  // Watchdog-in-halt arming lasts until the next reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wdh_armed_q <= 1'b0;
    else if (watchdog_in_halt_op && mode_q == MODE_RUN)
      wdh_armed_q <= 1'b1; // [R10]
  end

  // Watchdog run and restart; reset clears it as at power-on
  assign wd.run = (mode_q == MODE_RUN) ||
                  ((mode_q == MODE_HALT) && wdh_armed_q); // [R10] [R11]
  assign wd.clear = sys_rst ||
                    (watchdog_refresh_op && mode_q == MODE_RUN); // [R9]

  wdog_timer #(
    .CYCLES(WDT_CYCLES)
  ) u_wdog (
    .clk(clk),
    .rst(rst),
    .wd(wd.timer)
  );

  // Refresh writes fixed flag values into the core flag register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flag_we_q <= 1'b0;
      flag_zsv_q <= 3'h0;
    end
    else
    begin
      flag_we_q <= watchdog_refresh_op && mode_q == MODE_RUN; // [R12]
      flag_zsv_q <= `WDT_FLAG_ZSV; // [R12]
    end
  end

  // Request sources; frozen in stop since the timer clock is off
  assign set_vec = {2'b00, timer_one, timer_zero,
                    pin_rise[`PIN_WAKE], pin_rise[`PIN_EXT],
                    pin_rise[`PIN_VSYNC], soft_irq_req} &
                   {`IRQ_W{clocks_on}}; // [R14] [R15]
  assign clr_vec = (wr_acc && widx == `IDX_IRQ_FLAGS) ?
                   pwdata[`IRQ_W-1:0] : '0;

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags_q <= `IRQ_FLAGS_RST;
    else
      flags_q <= ((flags_q & ~clr_vec) | set_vec) & `IRQ_VALID_MASK; // [R15]
  end

  // Mask register, same layout
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mask_q <= `IRQ_MASK_RST;
    else if (wr_acc && widx == `IDX_IRQ_MASK)
      mask_q <= pwdata[`IRQ_W-1:0] & `IRQ_VALID_MASK;
  end

  assign pend_vec = flags_q & mask_q;
  assign pending = |pend_vec; // [R3] [R15]

  // Level interrupt and highest-priority request number
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_q <= 1'b0;
      irq_vector_q <= '0;
    end
    else
    begin
      irq_q <= pending;
      irq_vector_q <= first_set(pend_vec); // [R15]
    end
  end

  // APB decode; one wait state so read data comes from a flop
  assign widx = paddr[11:2];
  assign acc = psel && penable && pready_q;
  assign wr_acc = acc && pwrite;

  always_comb
  begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (widx)
      `IDX_IRQ_FLAGS: rd_data[`IRQ_W-1:0] = flags_q;
      `IDX_IRQ_MASK: rd_data[`IRQ_W-1:0] = mask_q;
      `IDX_STATUS:
      begin
        rd_data[`STAT_MODE_LSB +: 2] = mode_q;
        rd_data[`STAT_WDH_BIT] = wdh_armed_q;
        rd_data[`STAT_CAUSE_LSB +: 2] = cause_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer registered one cycle into the access phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !rd_hit;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_data : '0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign osc_run = osc_run_q;
  assign cpu_clk_en = cpu_clk_en_q;
  assign timer_clk_en = timer_clk_en_q;
  assign dev_reset = dev_reset_q;
  assign fetch_start = fetch_start_q;
  assign fetch_addr = fetch_addr_q; // [R6]
  assign halt_resume = halt_resume_q;
  assign flag_we = flag_we_q;
  assign flag_zsv = flag_zsv_q;
  assign irq = irq_q;
  assign irq_vector = irq_vector_q;
endmodule : standby_watchdog_control

// file: standby_regs.svh
`ifndef STANDBY_REGS_SVH
`define STANDBY_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_IRQ_FLAGS 10'h0FA
`define IDX_IRQ_MASK 10'h001
`define IDX_STATUS 10'h002

// Field layout and reset values
`define IRQ_VALID_MASK 8'h3F
`define IRQ_FLAGS_RST 8'h00
`define IRQ_MASK_RST 8'h00
`define CAUSE_RST 2'h0
`define IRQ_W 8
`define IRQ_SRC_N 6
`define STAT_MODE_LSB 0
`define STAT_WDH_BIT 2
`define STAT_CAUSE_LSB 3

// Restart address after reset or stop release
`define RESTART_ADDR 16'h000C

// Flag values written by the watchdog refresh (zero, sign, overflow)
`define WDT_FLAG_ZSV 3'h0

// Watchdog timing
`define CLK_FREQ_HZ 200000000
`define WDT_TIMEOUT_MS 12
`define WDT_CYCLES_DFLT ((`CLK_FREQ_HZ / 1000) * `WDT_TIMEOUT_MS)

// Pin synchroniser slots
`define PIN_WAKE 0
`define PIN_EXT 1
`define PIN_VSYNC 2
`define PIN_SUPPLY 3
`define PIN_N 4

`endif

// file: standby_pkg.sv
package standby_pkg;

  // Power mode of the processor core
  typedef enum logic [1:0]
  {
    MODE_RUN = 2'b00,
    MODE_HALT = 2'b01,
    MODE_STOP = 2'b10
  } mode_t;

  typedef logic [7:0] irq_vec_t;
  typedef logic [2:0] irq_id_t;
  typedef logic [15:0] fetch_addr_t;

endpackage : standby_pkg

// file: wdog_if.sv
`timescale 1ns/1ps
interface wdog_if;
  logic run;
  logic clear;
  logic expired;

  modport ctrl
  (
    output run,
    output clear,
    input expired
  );

  modport timer
  (
    input run,
    input clear,
    output expired
  );
endinterface : wdog_if

// file: wdog_timer.sv
`timescale 1ns/1ps
module wdog_timer
#(
  parameter int unsigned CYCLES = 2400000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control from the sequencer
  wdog_if.timer wd
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_q;
  logic expired_q;

  // Counts only while run is high, so stop mode freezes it
  always_ff @(posedge clk)
  begin
    if (rst || wd.clear)
    begin
      count_q <= '0;
    end
    else if (wd.run)
    begin
      if (count_q == CW'(CYCLES - 1))
        count_q <= '0;
      else
        count_q <= count_q + CW'(1);
    end
  end

  // One-cycle expiry pulse at the last count
  always_ff @(posedge clk)
  begin
    if (rst || wd.clear)
      expired_q <= 1'b0;
    else
      expired_q <= wd.run && (count_q == CW'(CYCLES - 1));
  end

  assign wd.expired = expired_q;
endmodule : wdog_timer

// file: standby_watchdog_control_asserts.sv
`timescale 1ns/1ps
`include "standby_regs.svh"
module standby_watchdog_control_asserts
#(
  parameter int unsigned WDT_CYCLES = 2400000
)
(
  // Clock, reset, strobes and pins
  input wire logic clk,
  input wire logic rst,
  input wire logic halt_op,
  input wire logic stop_op,
  input wire logic watchdog_refresh_op,
  input wire logic wake_input_pin,
  input wire logic supply_low_reset,
  // Observed outputs
  input wire logic osc_run,
  input wire logic cpu_clk_en,
  input wire logic timer_clk_en,
  input wire logic dev_reset,
  input wire logic fetch_start,
  input wire logic [15:0] fetch_addr,
  input wire logic halt_resume,
  input wire logic flag_we,
  input wire logic [2:0] flag_zsv,
  input wire logic irq,
  input wire logic [2:0] irq_vector
);
  logic [31:0] run_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Run cycles since refresh; halt pauses it, so the bound is lenient
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset || watchdog_refresh_op)
      run_cnt_q <= '0;
    else if (cpu_clk_en)
      run_cnt_q <= run_cnt_q + 32'h1;
  end
  restart_addr_a: assert property (fetch_start |-> fetch_addr == 16'h000C)
    else $error("fetch address wrong");
  reset_fetch_a: assert property ($fell(dev_reset) |-> ##[0:1] fetch_start)
    else $error("no fetch after reset");
  halt_gate_a: assert property (halt_op && cpu_clk_en && !stop_op
    |-> ##2 timer_clk_en && osc_run) else $error("halt stopped timers");
  stop_gate_a: assert property (stop_op && cpu_clk_en && !wake_input_pin
    |-> ##2 !timer_clk_en && !cpu_clk_en) else $error("stop kept clocks");
  halt_exit_a: assert property (halt_resume |-> irq ##1 cpu_clk_en)
    else $error("halt exit wrong");
  wake_level_a: assert property (wake_input_pin [*4] |-> osc_run)
    else $error("wake did not run oscillator");
  supply_rst_a: assert property (supply_low_reset [*4] |-> dev_reset)
    else $error("supply low without reset");
  vector_range_a: assert property (irq |-> irq_vector < 3'h6)
    else $error("bad vector");
  refresh_flag_a: assert property (watchdog_refresh_op && cpu_clk_en &&
    !dev_reset && !$past(halt_op) && !$past(stop_op)
    |=> flag_we && flag_zsv == 3'h0) else $error("flags not written");
  wdog_bound_a: assert property (run_cnt_q <= WDT_CYCLES + 8)
    else $error("watchdog overdue");
endmodule : standby_watchdog_control_asserts

bind standby_watchdog_control standby_watchdog_control_asserts
  #(.WDT_CYCLES(WDT_CYCLES)) chk_i (.*);

// file: far_side.sv
`timescale 1ns/1ps
module far_side
(
  // Clock and controls
  input wire logic clk,
  input wire logic kick_en,
  // Levels and strobes asked for by the bench
  input wire logic [5:0] pin_req,
  input wire logic [3:0] op_req,
  input wire logic supply_req,
  // Pins and strobes to the block
  output logic [5:0] src,
  output logic supply_low,
  output logic [3:0] op,
  output logic kick
);
  logic [5:0] tick;
  logic op_prev;
  initial
  begin
    kick = 1'b0;
    tick = '0;
    op_prev = 1'b0;
  end
  // Software keeps refreshing well inside the period
  always @(posedge clk)
  begin
    tick <= tick + 6'h1;
    kick <= kick_en && (tick == 6'h3F);
    op_prev <= |op_req;
  end
  // Pin levels and the supply monitor follow the bench
  assign src = pin_req;
  assign supply_low = supply_req;
  // Code never issues strobes back to back; a no-operation leads
  assign op = op_prev ? 4'h0 : op_req;
endmodule : far_side

// file: standby_watchdog_control_tb.sv
`timescale 1ns/1ps
`include "standby_regs.svh"
module standby_watchdog_control_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, kick_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic osc_run, cpu_clk_en, timer_clk_en, dev_reset, fetch_start;
  logic halt_resume, flag_we, irq, err, kick, supply_low;
  logic seen_f, seen_r, seen_h, seen_w;
  logic [15:0] fetch_addr;
  logic [2:0] flag_zsv, irq_vector;
  logic [5:0] src;
  logic [3:0] op;
  logic [5:0] pin_req;
  logic [3:0] op_req;
  logic supply_req;
  int err_count, num_checks, cyc;
  localparam logic [11:0] A_FLG = {`IDX_IRQ_FLAGS, 2'b00};
  localparam logic [11:0] A_MSK = {`IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_ST = {`IDX_STATUS, 2'b00};

  standby_watchdog_control #(.WDT_CYCLES(200)) dut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_input_pin(src[3]), .external_event_pin(src[2]),
    .vsync_filtered(src[1]), .supply_low_reset(supply_low),
    .halt_op(op[0]), .stop_op(op[1]), .watchdog_refresh_op(op[2] | kick),
    .watchdog_in_halt_op(op[3]), .soft_irq_req(src[0]),
    .timer_zero(src[4]), .timer_one(src[5]), .osc_run(osc_run),
    .cpu_clk_en(cpu_clk_en), .timer_clk_en(timer_clk_en),
    .dev_reset(dev_reset), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr), .halt_resume(halt_resume), .flag_we(flag_we),
    .flag_zsv(flag_zsv), .irq(irq), .irq_vector(irq_vector));
  far_side far (.clk(clk), .kick_en(kick_en), .pin_req(pin_req),
    .op_req(op_req), .supply_req(supply_req), .src(src),
    .supply_low(supply_low), .op(op), .kick(kick));

  always #2.5 clk = ~clk;
  // Sticky witnesses of one-cycle pulses
  always @(posedge clk)
  begin
    if (fetch_start) seen_f <= 1'b1;
    if (dev_reset) seen_r <= 1'b1;
    if (halt_resume) seen_h <= 1'b1;
    if (flag_we) seen_w <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Async pins held long enough for the synchroniser
  task automatic fire(input int i);
    @(posedge clk) pin_req[i] <= 1'b1;
    repeat ((i inside {1, 2, 3}) ? 4 : 1) @(posedge clk);
    pin_req[i] <= 1'b0;
  endtask : fire
  // One decoder strobe after an idle cycle
  task automatic exec(input int k);
    @(posedge clk) op_req <= '0;
    @(posedge clk) op_req[k] <= 1'b1;
    @(posedge clk) op_req[k] <= 1'b0;
  endtask : exec
  task automatic clr();
    seen_f = 0;
    seen_r = 0;
    seen_h = 0;
    seen_w = 0;
  endtask : clr

  initial
  begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; kick_en = 1; cyc = 0; clr();
    pin_req = '0; op_req = '0; supply_req = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("fetch", seen_f, 1);
    chk("addr", fetch_addr, 16'h000C);
    apb(0, A_FLG, 0); chk("flags", rd, 0);
    apb(1, A_MSK, 32'h3F); apb(0, A_MSK, 0); chk("mask", rd, 32'h3F);
    apb(0, 12'hFFC, 0); chk("unmapped", {rd[30:0], err}, 1);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      fire(i); repeat (4) @(posedge clk);
      apb(0, A_FLG, 0); chk("flag", rd, 32'h1 << i);
      chk("irq", {irq_vector, irq}, {i[2:0], 1'b1});
      apb(1, A_FLG, 32'h1 << i); apb(0, A_FLG, 0); chk("clear", rd, 0);
    end
    apb(1, A_MSK, 0); fire(4); repeat (4) @(posedge clk);
    chk("masked", irq, 0);
    apb(1, A_FLG, 32'h3F); apb(1, A_MSK, 32'h3F);
    $display("test requests done");
    clr(); exec(0); repeat (3) @(posedge clk);
    chk("halt", {cpu_clk_en, timer_clk_en, osc_run}, 3'b011);
    apb(0, A_ST, 0);
    chk("mode", rd[1:0], 2'h1);
    fire(4); repeat (3) @(posedge clk);
    chk("resume", {seen_h, cpu_clk_en}, 2'b11);
    apb(1, A_FLG, 32'h3F);
    $display("test halt done");
    exec(1); repeat (3) @(posedge clk);
    chk("stop", {timer_clk_en, osc_run}, 0);
    clr(); fire(4); repeat (300) @(posedge clk);
    chk("frozen", {seen_r, osc_run}, 0);
    fire(3); repeat (6) @(posedge clk);
    chk("wake", {osc_run, seen_f}, 2'b11);
    apb(1, A_FLG, 32'h3F);
    $display("test stop done");
    clr(); exec(2); repeat (2) @(posedge clk);
    chk("refresh", {seen_w, flag_zsv}, 4'h8);
    kick_en <= 1'b0; repeat (150) @(posedge clk);
    chk("early", seen_r, 0);
    repeat (100) @(posedge clk);
    chk("expired", seen_r, 1);
    apb(0, A_ST, 0); chk("cause", rd[3], 1);
    $display("test watchdog done");
    exec(3); exec(0); clr(); repeat (300) @(posedge clk);
    chk("halt wdog", seen_r, 1);
    $display("test halt watchdog done");
    kick_en <= 1'b1; clr(); supply_req <= 1'b1; repeat (6) @(posedge clk);
    chk("supply", dev_reset, 1);
    supply_req <= 1'b0; repeat (8) @(posedge clk);
    chk("restart", {dev_reset, seen_f}, 2'b01);
    $display("test supply done");
    finish_test();
  end
endmodule : standby_watchdog_control_tb
